// [hw/srw_receiver.sv]
// Serial video receiver back end: decoder, framer use, lock, carrier and register slave.
`timescale 1ns/1ns
module srw_receiver import srw_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic serial_input,
	input wire logic serial_bit_stb,
	input wire logic equalizer_bypass_strap,
	input wire logic decode_bypass_strap,
	output logic equalizer_on,
	output logic [WORD_W-1:0] data_out,
	output logic word_clock_out,
	output logic line_timing,
	output logic signal_acquired,
	output logic carrier_present_n,
	output logic irq
);
	logic bypass_reg;
	logic prev_raw_reg;
	logic [SCR_LEN-1:0] scr_reg;
	logic dec_bit_reg;
	logic dec_stb_reg;
	logic nrz;
	logic desc;
	srw_word_s word;
	logic wclk;
	logic realign;
	logic [TMR_W-1:0] quiet_reg;
	logic carrier_reg;
	srw_lock_e lk_state;
	logic [TMR_W-1:0] lk_cnt;
	logic [EVT_W-1:0] evt_reg;
	logic [EVT_W-1:0] evt_set;
	logic [EVT_W-1:0] evt_clr;
	logic [EVT_W-1:0] mask_reg;
	logic [31:0] rd_mux;
	logic access;
	logic edge_seen;

	// Straps are sampled each cycle; they act independently of each other.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			equalizer_on <= 1'b1;
			bypass_reg <= 1'b0;
		end else if (ce) begin
			equalizer_on <= !equalizer_bypass_strap;
			bypass_reg <= decode_bypass_strap;
		end
	end

	// NRZI is undone by x + 1, then the self-synchronising descrambler.
	assign nrz = serial_input ^ prev_raw_reg;
	assign desc = nrz ^ scr_reg[SCR_TAP_A] ^ scr_reg[SCR_TAP_B];

	// Decoder pipeline; both stages keep running in bypass so a return is seamless.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prev_raw_reg <= 1'b0;
			scr_reg <= '0;
			dec_bit_reg <= 1'b0;
			dec_stb_reg <= 1'b0;
		end else if (ce) begin
			dec_stb_reg <= serial_bit_stb;
			if (serial_bit_stb) begin
				prev_raw_reg <= serial_input;
				scr_reg <= {scr_reg[SCR_LEN-2:0], nrz};
				dec_bit_reg <= bypass_reg ? serial_input : desc;
			end
		end
	end

	srw_word_align u_align (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.ce(ce),
		.bit_in(dec_bit_reg),
		.bit_stb(dec_stb_reg),
		.word(word),
		.wclk(wclk),
		.realign(realign)
	);

	// Parallel port and line timing flag.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			data_out <= WORD_RST;
			word_clock_out <= 1'b0;
			line_timing <= 1'b0;
		end else if (ce) begin
			word_clock_out <= wclk;
			if (word.valid) begin
				data_out <= word.data;
			end
			// In decode bypass the flag still follows header matches, but those
			// are not video headers, so its level means nothing there.
			if (word.valid && word.is_id) begin
				line_timing <= word.eav;
			end
		end
	end

	// Carrier: any raw transition restarts a quiet timer; a full quiet period drops it.
	assign edge_seen = serial_bit_stb && (serial_input != prev_raw_reg);
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			quiet_reg <= '0;
			carrier_reg <= 1'b0;
			carrier_present_n <= 1'b1;
		end else if (ce) begin
			if (edge_seen) begin
				quiet_reg <= '0;
				carrier_reg <= 1'b1;
			end else if (quiet_reg == TMR_W'(CARRIER_CYC - 1)) begin
				carrier_reg <= 1'b0;
			end else begin
				quiet_reg <= quiet_reg + 1'b1;
			end
			carrier_present_n <= !carrier_reg;
		end
	end

	// Lock: start timing at the first ID word, restart on realign or carrier loss.
	// A realign drops the indication for at least 38 us, until the next ID word restarts the full delay.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lk_state <= LK_IDLE;
			lk_cnt <= '0;
			signal_acquired <= 1'b0;
		end else if (ce) begin
			if (!carrier_reg || realign) begin
				lk_state <= LK_IDLE;
				lk_cnt <= '0;
			end else begin
				case (lk_state)
					LK_IDLE: begin
						if (word.valid && word.is_id) begin
							lk_state <= LK_WAIT;
						end
						lk_cnt <= '0;
					end
					LK_WAIT: begin
						if (lk_cnt == TMR_W'(LOCK_CYC - 1)) begin
							lk_state <= LK_LOCKED;
						end else begin
							lk_cnt <= lk_cnt + 1'b1;
						end
					end
					LK_LOCKED: begin
						lk_cnt <= lk_cnt;
					end
					default: begin
						lk_state <= LK_IDLE;
					end
				endcase
			end
			signal_acquired <= lk_state == LK_LOCKED;
		end
	end

	// Event sources, each a one-cycle pulse.
	always_comb begin
		evt_set = '0;
		evt_set[EV_EAV] = word.valid && word.is_id && word.eav;
		evt_set[EV_SAV] = word.valid && word.is_id && !word.eav;
		evt_set[EV_LOCK] = lk_state == LK_LOCKED && !signal_acquired;
		evt_set[EV_CARRIER_LOST] = carrier_reg && !edge_seen
			&& quiet_reg == TMR_W'(CARRIER_CYC - 1);
	end

	// Read data mux; unmapped addresses read as zero.
	always_comb begin
		rd_mux = RDATA_RST;
		case (avs_address)
			ADDR_STATUS: begin
				rd_mux[ST_LOCK] = signal_acquired;
				rd_mux[ST_CARRIER] = carrier_reg;
				rd_mux[ST_LINE] = line_timing;
				rd_mux[ST_DEC_BYP] = bypass_reg;
				rd_mux[ST_EQ_BYP] = !equalizer_on;
			end
			ADDR_EVENT: rd_mux[EVT_W-1:0] = evt_reg;
			ADDR_MASK: rd_mux[EVT_W-1:0] = mask_reg;
			ADDR_WORD: rd_mux[WORD_W-1:0] = data_out;
			default: rd_mux = RDATA_RST;
		endcase
	end

	// Slave answers one cycle after the request is seen; it completes the next edge.
	assign access = !avs_waitrequest && (avs_read || avs_write);
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= RDATA_RST;
		end else if (ce) begin
			if ((avs_read || avs_write) && avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
				avs_readdata <= avs_read ? rd_mux : RDATA_RST;
			end else begin
				avs_waitrequest <= 1'b1;
			end
		end
	end

	// Only bits already returned are cleared, so a late event survives the read.
	assign evt_clr = (access && avs_read && avs_address == ADDR_EVENT) ?
		avs_readdata[EVT_W-1:0] : '0;

	// Sticky events, mask and interrupt; a set in the clear cycle wins.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			evt_reg <= '0;
			mask_reg <= MASK_RST;
			irq <= 1'b0;
		end else if (ce) begin
			evt_reg <= (evt_reg & ~evt_clr) | evt_set;
			if (access && avs_write && avs_address == ADDR_MASK) begin
				mask_reg <= avs_writedata[EVT_W-1:0];
			end
			irq <= |(evt_reg & mask_reg);
		end
	end

	a_eq_select: assert property (@(posedge clk_sys) disable iff (!rst_b)
		ce && $stable(equalizer_bypass_strap) |=> equalizer_on == !$past(equalizer_bypass_strap))
		else $error("equalizer select does not follow strap");
	a_bypass_path: assert property (@(posedge clk_sys) disable iff (!rst_b)
		ce && bypass_reg && serial_bit_stb |=> dec_bit_reg == $past(serial_input))
		else $error("bypass bit differs from input");
	a_descramble: assert property (@(posedge clk_sys) disable iff (!rst_b)
		ce && !bypass_reg && serial_bit_stb |=>
		dec_bit_reg == ($past(serial_input) ^ $past(prev_raw_reg) ^ $past(scr_reg[SCR_TAP_A])
		^ $past(scr_reg[SCR_TAP_B])))
		else $error("descrambled bit wrong");
	a_h_high_eav: assert property (@(posedge clk_sys) disable iff (!rst_b)
		ce && word.valid && word.is_id && word.eav |=> line_timing)
		else $error("line timing not high after end ID");
	a_h_low_sav: assert property (@(posedge clk_sys) disable iff (!rst_b)
		ce && word.valid && word.is_id && !word.eav |=> !line_timing)
		else $error("line timing not low after start ID");
	a_lock_delay: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(signal_acquired) |-> $past(lk_cnt, 2) == TMR_W'(LOCK_CYC - 1))
		else $error("lock rose without full delay");
	a_carrier_loss: assert property (@(posedge clk_sys) disable iff (!rst_b)
		ce && evt_set[EV_CARRIER_LOST] ##1 ce |=> carrier_present_n)
		else $error("carrier output still low after loss");
	a_carrier_seen: assert property (@(posedge clk_sys) disable iff (!rst_b)
		ce && edge_seen ##1 ce |=> !carrier_present_n)
		else $error("carrier output high after transition");
	a_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_b)
		ce |=> irq == |($past(evt_reg) & $past(mask_reg)))
		else $error("interrupt not the masked event level");

	c_eav_seen: cover property (@(posedge clk_sys) disable iff (!rst_b) evt_set[EV_EAV]);
	c_lock_rise: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(signal_acquired));
	c_carrier_lost: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(carrier_present_n));
	c_event_read: cover property (@(posedge clk_sys) disable iff (!rst_b) |evt_clr);
endmodule // srw_receiver

// [hw/srw_word_align.sv]
// Word framer: finds timing reference headers and cuts the bit stream into words.
`timescale 1ns/1ns
module srw_word_align import srw_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic bit_in,
	input wire logic bit_stb,
	output srw_word_s word,
	output logic wclk,
	output logic realign
);
	logic [SHIFT_W-1:0] sr_reg;
	logic [SHIFT_W-1:0] sr_next;
	logic [3:0] cnt_reg;
	logic id_pend_reg;
	logic pre_hit;

	// Bits arrive first-bit-first, so the newest bit enters at the top.
	assign sr_next = {bit_in, sr_reg[SHIFT_W-1:1]};
	assign pre_hit = bit_stb && srw_is_preamble(sr_next);

	// Shift window.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sr_reg <= '0;
		end else if (ce && bit_stb) begin
			sr_reg <= sr_next;
		end
	end

	// Divide-by-ten bit counter, forced to its start by a header.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= '0;
			wclk <= 1'b0;
			realign <= 1'b0;
		end else if (ce) begin
			realign <= pre_hit && cnt_reg != BIT_CNT_LAST;
			if (pre_hit) begin
				cnt_reg <= '0;
			end else if (bit_stb) begin
				cnt_reg <= (cnt_reg == BIT_CNT_LAST) ? 4'h0 : cnt_reg + 4'h1;
			end
			wclk <= cnt_reg < WCLK_HIGH_BITS;
		end
	end

	// Word output; the word right after a preamble is the ID word.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			word <= '0;
			id_pend_reg <= 1'b0;
		end else if (ce) begin
			word.valid <= 1'b0;
			if (pre_hit) begin
				id_pend_reg <= 1'b1;
			end else if (bit_stb && cnt_reg == BIT_CNT_LAST) begin
				word.data <= sr_next[SHIFT_W-1:SHIFT_W-WORD_W];
				word.valid <= 1'b1;
				word.is_id <= id_pend_reg && sr_next[SHIFT_W-WORD_W+ID_FIXED_BIT];
				word.eav <= sr_next[SHIFT_W-WORD_W+ID_H_BIT];
				id_pend_reg <= 1'b0;
			end
		end
	end

	a_div_reset: assert property (@(posedge clk_sys) disable iff (!rst_b)
		ce && pre_hit |=> cnt_reg == 4'h0)
		else $error("word divider not reset by header");
	a_id_after_pre: assert property (@(posedge clk_sys) disable iff (!rst_b)
		word.valid && word.is_id |-> $past(id_pend_reg))
		else $error("ID word flagged without preamble");
	a_word_clock: assert property (@(posedge clk_sys) disable iff (!rst_b)
		ce && cnt_reg == BIT_CNT_LAST |=> !wclk)
		else $error("word clock high in last bit");
endmodule // srw_word_align

// [include/srw_pkg.sv]
// Package for the serial video word recovery block: constants, types and bus map.
package srw_pkg;
	// Word framing.
	localparam int WORD_W = 10;
	localparam int SHIFT_W = 4 * WORD_W;
	localparam logic [3:0] BIT_CNT_LAST = 4'h9;
	localparam logic [3:0] WCLK_HIGH_BITS = 4'h5;
	localparam logic [9:0] TRS_ONES = 10'h3FF;
	localparam logic [9:0] TRS_ZEROS = 10'h000;
	localparam int ID_H_BIT = 6;
	localparam int ID_FIXED_BIT = 9;
	// Self-synchronising descrambler taps: delay 4 and delay 9.
	localparam int SCR_LEN = 9;
	localparam int SCR_TAP_A = 3;
	localparam int SCR_TAP_B = 8;
	// Timing.
	localparam int CLK_MHZ = 100;
	localparam int LOCK_US = 38;
	localparam int LOCK_CYC = LOCK_US * CLK_MHZ;
	localparam int CARRIER_US = 1;
	localparam int CARRIER_CYC = CARRIER_US * CLK_MHZ;
	localparam int TMR_W = 12;
	// Register byte addresses.
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_EVENT = 4'h4;
	localparam logic [3:0] ADDR_MASK = 4'h8;
	localparam logic [3:0] ADDR_WORD = 4'hC;
	// Status fields.
	localparam int ST_LOCK = 0;
	localparam int ST_CARRIER = 1;
	localparam int ST_LINE = 2;
	localparam int ST_DEC_BYP = 3;
	localparam int ST_EQ_BYP = 4;
	// Event fields, shared by the event and mask registers.
	localparam int EVT_W = 4;
	localparam int EV_EAV = 0;
	localparam int EV_SAV = 1;
	localparam int EV_LOCK = 2;
	localparam int EV_CARRIER_LOST = 3;
	// Reset values.
	localparam logic [EVT_W-1:0] MASK_RST = 4'h0;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;
	localparam logic [9:0] WORD_RST = 10'h000;

	typedef struct packed {
		logic [WORD_W-1:0] data;
		logic valid;
		logic is_id;
		logic eav;
	} srw_word_s;

	typedef enum logic [1:0] {LK_IDLE, LK_WAIT, LK_LOCKED} srw_lock_e;

	// True when the three preamble words sit in the shift window, oldest lowest.
	function automatic logic srw_is_preamble(input logic [SHIFT_W-1:0] sr);
		return sr[19:10] == TRS_ONES && sr[29:20] == TRS_ZEROS && sr[39:30] == TRS_ZEROS;
	endfunction
endpackage

// [tb/srw_source.sv]
// Partner model: serial video source that frames words and can scramble and NRZI-code them.
`timescale 1ns/1ns
module srw_source (
	input wire logic clk_sys,
	input wire logic encode,
	output logic serial_input,
	output logic serial_bit_stb
);
	logic [8:0] scr_hist;
	logic nrzi_last;

	// Idle line with no strobes; it holds its level, so no transitions show between words.
	initial begin
		serial_input = 1'b0;
		serial_bit_stb = 1'b0;
		scr_hist = 9'h000;
		nrzi_last = 1'b0;
	end

	// One bit every second cycle, first bit is word bit 0.
	task automatic send_word(input logic [9:0] w);
		logic s;
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_sys);
			s = w[i] ^ scr_hist[3] ^ scr_hist[8];
			scr_hist = {scr_hist[7:0], s};
			nrzi_last = nrzi_last ^ s;
			serial_input <= encode ? nrzi_last : w[i];
			serial_bit_stb <= 1'b1;
			@(posedge clk_sys);
			serial_bit_stb <= 1'b0;
		end
	endtask
endmodule // srw_source

// [tb/testbench.sv]
// Testbench for the serial video word recovery receiver.
`timescale 1ns/1ns
module testbench import srw_pkg::*;;
	logic clk_sys, rst_b, ce, avs_read, avs_write, avs_waitrequest, src_encode;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic serial_input, serial_bit_stb, eq_strap, dec_strap, equalizer_on;
	logic [WORD_W-1:0] data_out;
	logic word_clock_out, line_timing, signal_acquired, carrier_present_n, irq, wck_q;
	int n_mismatch, n_tests, n_wck;

	srw_receiver u_srw_receiver (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .serial_input(serial_input),
		.serial_bit_stb(serial_bit_stb), .equalizer_bypass_strap(eq_strap),
		.decode_bypass_strap(dec_strap), .equalizer_on(equalizer_on), .data_out(data_out),
		.word_clock_out(word_clock_out), .line_timing(line_timing),
		.signal_acquired(signal_acquired), .carrier_present_n(carrier_present_n), .irq(irq));

	srw_source u_srw_source (.clk_sys(clk_sys), .encode(src_encode),
		.serial_input(serial_input), .serial_bit_stb(serial_bit_stb));

	// Free-running 100 MHz clock.
	always #5 clk_sys = ~clk_sys;

	// Counts rising edges of the word clock so its divide ratio can be checked.
	always @(posedge clk_sys) begin
		wck_q <= word_clock_out;
		if (word_clock_out === 1'b1 && wck_q === 1'b0)
			n_wck++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One Avalon transfer; the request is held until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		if (n >= 50)
			chk(32'h0000_0000, 32'h0000_0001);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// Timing reference: preamble words, then the ID word, then time for outputs to settle.
	task automatic header(input logic [9:0] id);
		u_srw_source.send_word(TRS_ONES);
		u_srw_source.send_word(TRS_ZEROS);
		u_srw_source.send_word(TRS_ZEROS);
		u_srw_source.send_word(id);
		repeat (6) @(posedge clk_sys);
	endtask

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Watchdog sized well above the roughly 51 us the tests need.
	initial begin
		#300000;
		n_mismatch++;
		end_sim;
	end

	initial begin
		clk_sys = 1'b0;
		rst_b = 1'b0;
		ce = 1'b1;
		{avs_read, avs_write, eq_strap, dec_strap} = 4'h0;
		avs_address = 4'h0;
		avs_writedata = 32'h0000_0000;
		src_encode = 1'b1;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk(carrier_present_n, 32'h1);
		chk(signal_acquired, 32'h0);
		bus(1'b0, ADDR_MASK, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 4'h6, 32'h0);
		chk(rd, 32'h0);
		// Every strap combination, each strap seen on its own.
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_sys);
			eq_strap <= k[1];
			dec_strap <= k[0];
			repeat (3) @(posedge clk_sys);
			chk(equalizer_on, !k[1]);
			bus(1'b0, ADDR_STATUS, 32'h0);
			chk({rd[ST_EQ_BYP], rd[ST_DEC_BYP]}, k[1:0]);
		end
		@(posedge clk_sys);
		{eq_strap, dec_strap} <= 2'b00;
		bus(1'b1, ADDR_MASK, 32'h1);
		n_wck = 0;
		repeat (10) u_srw_source.send_word(10'h155);
		// The last wrap reaches the word clock pin four edges after its bit strobe.
		repeat (6) @(posedge clk_sys);
		chk(n_wck, 32'd10);
		header(10'h2D8);
		chk(line_timing, 32'h1);
		chk(data_out, 32'h2D8);
		chk(irq, 32'h1);
		bus(1'b0, ADDR_EVENT, 32'h0);
		chk(rd, 32'h1);
		repeat (3) @(posedge clk_sys);
		chk(irq, 32'h0);
		u_srw_source.send_word(10'h0AB);
		repeat (6) @(posedge clk_sys);
		chk(data_out, 32'h0AB);
		header(10'h200);
		chk(line_timing, 32'h0);
		bus(1'b0, ADDR_EVENT, 32'h0);
		chk(rd, 32'h2);
		// Lock needs 38 us of aligned words; 180 words fall short, 200 reach it.
		repeat (180) u_srw_source.send_word(10'h155);
		chk(signal_acquired, 32'h0);
		repeat (20) u_srw_source.send_word(10'h155);
		repeat (6) @(posedge clk_sys);
		chk(signal_acquired, 32'h1);
		chk(carrier_present_n, 32'h0);
		bus(1'b0, ADDR_EVENT, 32'h0);
		chk(rd & 32'h4, 32'h4);
		repeat (120) @(posedge clk_sys);
		chk(carrier_present_n, 32'h1);
		bus(1'b0, ADDR_EVENT, 32'h0);
		chk(rd & 32'h8, 32'h8);
		// Raw stream with decoding bypassed must come out unchanged.
		@(posedge clk_sys);
		dec_strap <= 1'b1;
		src_encode <= 1'b0;
		repeat (3) u_srw_source.send_word(10'h155);
		header(10'h2D8);
		u_srw_source.send_word(10'h0AB);
		repeat (6) @(posedge clk_sys);
		chk(data_out, 32'h0AB);
		bus(1'b0, ADDR_WORD, 32'h0);
		chk(rd, 32'h0000_00AB);
		// Clock enable low freezes the quiet timer, so the carrier must outlast a long gap.
		@(posedge clk_sys);
		ce <= 1'b0;
		repeat (150) @(posedge clk_sys);
		chk(carrier_present_n, 32'h0);
		ce <= 1'b1;
		repeat (120) @(posedge clk_sys);
		chk(carrier_present_n, 32'h1);
		end_sim;
	end
endmodule // testbench
